// ==== rtl/t8c_pkg.sv ====
// Purpose: Shared constants and types of the 8-bit timer/counter with two compare channels.
// Assumes: Registers are reached over APB with one aligned 32-bit word per register.
// Notes: All offsets are byte addresses; narrow registers sit in the low bits.
package t8c_pkg;
  localparam int T8C_CNT_W = 8;
  localparam int T8C_NUM_CH = 2;

  // Register byte offsets.
  localparam logic [7:0] T8C_OFS_CTRL_A = 8'h00;
  localparam logic [7:0] T8C_OFS_CTRL_B = 8'h04;
  localparam logic [7:0] T8C_OFS_CTRL_C = 8'h08;
  localparam logic [7:0] T8C_OFS_COUNT = 8'h0c;
  localparam logic [7:0] T8C_OFS_CMP_A = 8'h10;
  localparam logic [7:0] T8C_OFS_CMP_B = 8'h14;
  localparam logic [7:0] T8C_OFS_FLAGS = 8'h18;
  localparam logic [7:0] T8C_OFS_MASK = 8'h1c;

  // Field positions.
  localparam int T8C_FOC_A_BIT = 7;
  localparam int T8C_FOC_B_BIT = 6;
  localparam int T8C_FLG_OVF = 0;
  localparam int T8C_FLG_A = 1;
  localparam int T8C_FLG_B = 2;

  // Reset values and counter limits.
  localparam logic [7:0] T8C_RST_8 = 8'h00;
  localparam logic [7:0] T8C_MAX = 8'hff;
  localparam logic [7:0] T8C_BOTTOM = 8'h00;
  localparam logic [2:0] T8C_TICK_OFF = 3'h0;

  // Prescaler taps as counter widths: divide by 8, 64, 256 and 1024.
  localparam int T8C_DIV8_W = 3;
  localparam int T8C_DIV64_W = 6;
  localparam int T8C_DIV256_W = 8;
  localparam int T8C_DIV1024_W = 10;

  typedef enum logic [2:0] {
    T8C_WGM_NORMAL = 3'h0,
    T8C_WGM_PC_MAX = 3'h1,
    T8C_WGM_CTC = 3'h2,
    T8C_WGM_FAST_MAX = 3'h3,
    T8C_WGM_RSV4 = 3'h4,
    T8C_WGM_PC_OCR = 3'h5,
    T8C_WGM_RSV6 = 3'h6,
    T8C_WGM_FAST_OCR = 3'h7
  } t8c_wgm_e;

  typedef struct packed {
    logic [1:0] com_a;
    logic [1:0] com_b;
    logic [1:0] rsvd;
    logic [1:0] wave_mode_sel;
  } t8c_ctrl_a_s;

  typedef struct packed {
    logic [3:0] rsvd;
    logic wave_mode_high_bit;
    logic [2:0] tick_source_sel;
  } t8c_ctrl_b_s;
endpackage : t8c_pkg

// ==== rtl/t8c_timer8_compare_core.sv ====
// Purpose: 8-bit timer/counter with two output compare channels behind an APB slave.
// Assumes: pclk at 100 MHz; tick_pin is asynchronous and is synchronised here.
// Notes: Zero-wait APB slave; unmapped addresses answer with pslverr.
module t8c_timer8_compare_core #(
  parameter int CNT_W = t8c_pkg::T8C_CNT_W
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External tick pin
  input wire logic tick_pin,
  // Interrupt request and service acknowledge: overflow, A, B
  output logic [2:0] irq_req,
  input wire logic [2:0] irq_ack,
  // Port pins of compare outputs A (bit 0) and B (bit 1)
  input wire logic [1:0] port_value,
  input wire logic [1:0] port_dir,
  output logic [1:0] compare_pin_o,
  output logic [1:0] compare_pin_oe
);
  if (CNT_W != 8) begin : g_chk
    $error("t8c_timer8_compare_core supports only an 8-bit counter");
  end

  t8c_pkg::t8c_ctrl_a_s timer_ctrl_a_q;
  t8c_pkg::t8c_ctrl_b_s timer_ctrl_b_q;
  logic [7:0] count_value_q;
  logic [7:0] cmp_act_q [2];
  logic [7:0] cmp_buf_q [2];
  logic [1:0] com [2];
  logic [2:0] flags_q;
  logic [2:0] mask_q;
  // One flop per channel, each owned by its own process in the channel loop.
  logic oc_q [2];
  logic dir_up_q;
  logic block_q;
  logic [9:0] pre_q;
  logic pin_s1_q, pin_s2_q, pin_s3_q;
  logic timer_tick;
  logic [2:0] wgm;
  logic pwm, fast, pcor, ocr_top;
  logic [7:0] top_val;
  logic at_top, at_bottom;
  logic wr, acc, addr_ok;
  logic wr_ctrl_c, wr_count, wr_flags;
  logic [1:0] hit, force_cmp;
  logic ovf_set;
  logic buf_upd;
  logic [2:0] flag_set, flag_clr;
  logic [31:0] rd_mux;

  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign wr_ctrl_c = wr & (paddr == t8c_pkg::T8C_OFS_CTRL_C);
  assign wr_count = wr & (paddr == t8c_pkg::T8C_OFS_COUNT);
  assign wr_flags = wr & (paddr == t8c_pkg::T8C_OFS_FLAGS);

  assign wgm = {timer_ctrl_b_q.wave_mode_high_bit, timer_ctrl_a_q.wave_mode_sel};
  assign pwm = wgm[0];
  assign fast = wgm[1] & wgm[0];
  assign pcor = ~wgm[1] & wgm[0];
  assign ocr_top = (wgm == t8c_pkg::T8C_WGM_CTC) | (wgm == t8c_pkg::T8C_WGM_PC_OCR)
                 | (wgm == t8c_pkg::T8C_WGM_FAST_OCR);
  assign top_val = ocr_top ? cmp_act_q[0] : t8c_pkg::T8C_MAX;
  assign at_top = (count_value_q == top_val);
  assign at_bottom = (count_value_q == t8c_pkg::T8C_BOTTOM);
  assign com[0] = timer_ctrl_a_q.com_a;
  assign com[1] = timer_ctrl_a_q.com_b;

  // Two flops before any logic sees the pin; the third only serves edge detection.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
    end else begin
      pin_s1_q <= tick_pin;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 10'h000;
    end else begin
      pre_q <= pre_q + 10'h001;
    end
  end

  always_comb begin
    unique case (timer_ctrl_b_q.tick_source_sel)
      3'h0: timer_tick = 1'b0;
      3'h1: timer_tick = 1'b1;
      3'h2: timer_tick = &pre_q[t8c_pkg::T8C_DIV8_W-1:0];
      3'h3: timer_tick = &pre_q[t8c_pkg::T8C_DIV64_W-1:0];
      3'h4: timer_tick = &pre_q[t8c_pkg::T8C_DIV256_W-1:0];
      3'h5: timer_tick = &pre_q[t8c_pkg::T8C_DIV1024_W-1:0];
      3'h6: timer_tick = pin_s3_q & ~pin_s2_q;
      3'h7: timer_tick = ~pin_s3_q & pin_s2_q;
    endcase
  end

  // Control registers; reserved bits are kept at zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_ctrl_a_q <= '0;
      timer_ctrl_b_q <= '0;
      mask_q <= 3'h0;
    end else if (wr) begin
      if (paddr == t8c_pkg::T8C_OFS_CTRL_A) begin
        timer_ctrl_a_q <= {pwdata[7:4], 2'h0, pwdata[1:0]};
      end
      if (paddr == t8c_pkg::T8C_OFS_CTRL_B) begin
        timer_ctrl_b_q <= {4'h0, pwdata[3:0]};
      end
      if (paddr == t8c_pkg::T8C_OFS_MASK) begin
        mask_q <= pwdata[2:0];
      end
    end
  end

  // Counter unit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value_q <= t8c_pkg::T8C_RST_8;
      dir_up_q <= 1'b1;
    end else if (wr_count) begin
      count_value_q <= pwdata[7:0];
    end else if (timer_tick) begin
      if (pcor) begin
        if (dir_up_q && at_top) begin
          dir_up_q <= 1'b0;
          count_value_q <= count_value_q - 8'h01;
        end else if (!dir_up_q && at_bottom) begin
          dir_up_q <= 1'b1;
          count_value_q <= count_value_q + 8'h01;
        end else if (dir_up_q) begin
          count_value_q <= count_value_q + 8'h01;
        end else begin
          count_value_q <= count_value_q - 8'h01;
        end
      end else if (at_top) begin
        count_value_q <= t8c_pkg::T8C_BOTTOM;
      end else begin
        count_value_q <= count_value_q + 8'h01;
      end
    end
  end

  // A counter write arms blocking; the next tick consumes it. A write wins over the tick.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_q <= 1'b0;
    end else if (wr_count) begin
      block_q <= 1'b1;
    end else if (timer_tick) begin
      block_q <= 1'b0;
    end
  end

  always_comb begin
    if (fast) begin
      ovf_set = timer_tick & at_top;
    end else if (pcor) begin
      ovf_set = timer_tick & ~dir_up_q & at_bottom;
    end else begin
      ovf_set = timer_tick & (count_value_q == t8c_pkg::T8C_MAX);
    end
  end

  // The buffer is copied where the count turns at top, so a PWM period never changes mid-way.
  assign buf_upd = timer_tick & pwm & at_top & (fast | dir_up_q);

  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    logic [7:0] ofs;
    logic foc_bit;
    logic oc_d;
    assign ofs = (ch == 0) ? t8c_pkg::T8C_OFS_CMP_A : t8c_pkg::T8C_OFS_CMP_B;
    assign foc_bit = (ch == 0) ? pwdata[t8c_pkg::T8C_FOC_A_BIT] : pwdata[t8c_pkg::T8C_FOC_B_BIT];
    assign hit[ch] = timer_tick & (count_value_q == cmp_act_q[ch]) & ~block_q;
    assign force_cmp[ch] = wr_ctrl_c & foc_bit & ~pwm;

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cmp_act_q[ch] <= t8c_pkg::T8C_RST_8;
        cmp_buf_q[ch] <= t8c_pkg::T8C_RST_8;
      end else begin
        if (wr && paddr == ofs) begin
          cmp_buf_q[ch] <= pwdata[7:0];
        end
        if (wr && paddr == ofs && !pwm) begin
          cmp_act_q[ch] <= pwdata[7:0];
        end else if (buf_upd) begin
          cmp_act_q[ch] <= cmp_buf_q[ch];
        end
      end
    end

    // Waveform generator: next state of the internal compare output.
    always_comb begin
      oc_d = oc_q[ch];
      if (!pwm) begin
        if (hit[ch] || force_cmp[ch]) begin
          unique case (com[ch])
            2'h0: oc_d = oc_q[ch];
            2'h1: oc_d = ~oc_q[ch];
            2'h2: oc_d = 1'b0;
            2'h3: oc_d = 1'b1;
          endcase
        end
      end else if (com[ch] == 2'h1) begin
        if (hit[ch] && ch == 0 && wgm[2]) begin
          oc_d = ~oc_q[ch];
        end
      end else if (com[ch] != 2'h0) begin
        if (fast && timer_tick && at_top) begin
          oc_d = ~com[ch][0];
        end else if (hit[ch]) begin
          oc_d = com[ch][0] ^ (pcor & ~dir_up_q);
        end
      end
    end

    // No mode field resets this state, so it survives mode changes.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        oc_q[ch] <= 1'b0;
      end else begin
        oc_q[ch] <= oc_d;
      end
    end

    assign compare_pin_o[ch] = (com[ch] != 2'h0) ? oc_q[ch] : port_value[ch];
    assign compare_pin_oe[ch] = port_dir[ch];
  end

  // Flags: a set in the same cycle as a clear wins.
  assign flag_set = {hit[1], hit[0], ovf_set};
  assign flag_clr = irq_ack | (wr_flags ? pwdata[2:0] : 3'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= 3'h0;
    end else begin
      flags_q <= (flags_q & ~flag_clr) | flag_set;
    end
  end

  assign irq_req = flags_q & mask_q;

  always_comb begin
    addr_ok = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      t8c_pkg::T8C_OFS_CTRL_A: rd_mux[7:0] = timer_ctrl_a_q;
      t8c_pkg::T8C_OFS_CTRL_B: rd_mux[7:0] = timer_ctrl_b_q;
      t8c_pkg::T8C_OFS_CTRL_C: rd_mux = 32'h0000_0000;
      t8c_pkg::T8C_OFS_COUNT: rd_mux[7:0] = count_value_q;
      t8c_pkg::T8C_OFS_CMP_A: rd_mux[7:0] = pwm ? cmp_buf_q[0] : cmp_act_q[0];
      t8c_pkg::T8C_OFS_CMP_B: rd_mux[7:0] = pwm ? cmp_buf_q[1] : cmp_act_q[1];
      t8c_pkg::T8C_OFS_FLAGS: rd_mux[2:0] = flags_q;
      t8c_pkg::T8C_OFS_MASK: rd_mux[2:0] = mask_q;
      default: addr_ok = 1'b0;
    endcase
  end

  assign prdata = (acc && !pwrite) ? rd_mux : 32'h0000_0000;
  assign pready = 1'b1;
  assign pslverr = acc & ~addr_ok;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  stopped_holds_a: assert property (
    timer_ctrl_b_q.tick_source_sel == t8c_pkg::T8C_TICK_OFF && !wr_count
    |=> $stable(count_value_q)) else $error("counter moved while stopped");
  write_wins_a: assert property (
    wr_count |=> count_value_q == $past(pwdata[7:0])) else $error("counter write lost");
  normal_inc_a: assert property (
    timer_tick && wgm == t8c_pkg::T8C_WGM_NORMAL && !wr_count
    |=> count_value_q == $past(count_value_q) + 8'h01) else $error("normal count wrong");
  normal_ovf_a: assert property (
    timer_tick && wgm == t8c_pkg::T8C_WGM_NORMAL && count_value_q == 8'hff && !wr_count
    |=> flags_q[0] && count_value_q == 8'h00) else $error("no overflow on wrap");
  match_flag_a: assert property (
    timer_tick && count_value_q == cmp_act_q[0] && !block_q |=> flags_q[1])
    else $error("match did not set flag A");
  write_blocks_a: assert property (
    block_q && timer_tick && !wr_count |=> !$rose(flags_q[1]) && !$rose(flags_q[2]))
    else $error("match not blocked after counter write");
  ctc_clear_a: assert property (
    timer_tick && wgm == t8c_pkg::T8C_WGM_CTC && count_value_q == cmp_act_q[0] && !wr_count
    |=> count_value_q == 8'h00) else $error("clear-on-match failed");
  force_toggle_a: assert property (
    wr_ctrl_c && pwdata[7] && !pwm && com[0] == 2'h1 && !hit[0]
    |=> oc_q[0] != $past(oc_q[0]) && $stable(flags_q[1])) else $error("force strobe wrong");
  pin_override_a: assert property (
    com[1] != 2'h0 |-> compare_pin_o[1] == oc_q[1] && compare_pin_oe[1] == port_dir[1])
    else $error("pin override wrong");
  com_zero_hold_a: assert property (
    com[0] == 2'h0 |=> $stable(oc_q[0])) else $error("output changed with mode zero");
  buffer_hold_a: assert property (
    pwm && !buf_upd && !(wr && paddr == t8c_pkg::T8C_OFS_CMP_B)
    |=> $stable(cmp_act_q[1])) else $error("active compare changed off top");
  set_wins_a: assert property (
    hit[0] && irq_ack[1] |=> flags_q[1]) else $error("flag set lost to clear");

  // Blocking must arm even while stopped, since the next tick may be far away.
  block_arm_a: assert property (
    wr_count |=> block_q) else $error("counter write did not arm blocking");
  force_flag_a: assert property (
    force_cmp[0] && !hit[0] |=> !$rose(flags_q[1])) else $error("force strobe set a flag");
  pc_turn_a: assert property (
    timer_tick && pcor && dir_up_q && at_top && !wr_count
    |=> !dir_up_q && count_value_q == $past(count_value_q) - 8'h01) else $error("no turn at top");
  pc_bottom_a: assert property (
    timer_tick && pcor && !dir_up_q && at_bottom && !wr_count
    |=> dir_up_q && flags_q[0]) else $error("no turn or overflow at bottom");
  fast_wrap_a: assert property (
    timer_tick && fast && at_top && !wr_count
    |=> count_value_q == 8'h00 && flags_q[0]) else $error("fast mode wrap wrong");
  direct_write_a: assert property (
    wr && paddr == t8c_pkg::T8C_OFS_CMP_A && !pwm
    |=> cmp_act_q[0] == $past(pwdata[7:0])) else $error("direct compare write lost");
  pin_port_a: assert property (
    com[0] == 2'h0 |-> compare_pin_o[0] == port_value[0]) else $error("port value not on pin");

  // Covers show that each main scenario is reached at least once.
  ctc_wrap_c: cover property (timer_tick && wgm == t8c_pkg::T8C_WGM_CTC && hit[0]);
  pc_turn_c: cover property (timer_tick && pcor && dir_up_q && at_top);
  fast_ovf_c: cover property (fast && ovf_set);
  buf_copy_c: cover property (buf_upd && cmp_buf_q[0] != cmp_act_q[0]);
  force_c: cover property (force_cmp[0] && com[0] != 2'h0);
endmodule : t8c_timer8_compare_core

// ==== tb/timer8_compare_core_tb.sv ====
// Purpose: Self-checking bench for the 8-bit timer with two compare channels.
// Assumes: Zero-wait APB slave; ticks come from the pin on rising edges (select 7).
// Notes: Each tick is one clean pin pulse, so counts are predictable cycle by cycle.
module timer8_compare_core_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic tick_pin = 1'b0;
  logic [2:0] irq_req;
  logic [2:0] irq_ack = 3'h0;
  logic [1:0] port_value = 2'h0;
  logic [1:0] port_dir = 2'h0;
  logic [1:0] compare_pin_o;
  logic [1:0] compare_pin_oe;
  logic [31:0] rd;
  logic last_err;
  int n_mismatch = 0;
  int comparisons = 0;

  t8c_timer8_compare_core uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tick_pin(tick_pin), .irq_req(irq_req), .irq_ack(irq_ack), .port_value(port_value),
    .port_dir(port_dir), .compare_pin_o(compare_pin_o), .compare_pin_oe(compare_pin_oe)
  );

  always #5 pclk = ~pclk;

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_mismatch++;
      wrap_up();
    end
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Registers updated at the completing edge are settled by the falling edge.
    @(negedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d});
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, {24'h000000, e});
  endtask : rchk

  // One rising edge on the pin; the synchroniser needs a few cycles to pass it on.
  task automatic tick;
    @(posedge pclk);
    tick_pin <= 1'b1;
    repeat (3) @(posedge pclk);
    tick_pin <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask : tick

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rchk(t8c_pkg::T8C_OFS_CTRL_A, 8'h00);
    rchk(t8c_pkg::T8C_OFS_COUNT, 8'h00);
    rchk(t8c_pkg::T8C_OFS_FLAGS, 8'h00);
    rchk(8'h20, 8'h00);
    chk(last_err, 1'b1);
    chk(compare_pin_o, port_value);
    $display("test reset done");

    wr(t8c_pkg::T8C_OFS_COUNT, 8'h5a);
    rchk(t8c_pkg::T8C_OFS_COUNT, 8'h5a);
    tick();
    rchk(t8c_pkg::T8C_OFS_COUNT, 8'h5a);
    wr(t8c_pkg::T8C_OFS_CTRL_B, 8'h07);
    tick();
    rchk(t8c_pkg::T8C_OFS_COUNT, 8'h5b);
    tick();
    rchk(t8c_pkg::T8C_OFS_COUNT, 8'h5c);
    $display("test count done");

    wr(t8c_pkg::T8C_OFS_COUNT, 8'hff);
    tick();
    rchk(t8c_pkg::T8C_OFS_COUNT, 8'h00);
    rchk(t8c_pkg::T8C_OFS_FLAGS, 8'h01);
    wr(t8c_pkg::T8C_OFS_MASK, 8'h07);
    repeat (2) @(posedge pclk);
    chk(irq_req, 3'h1);
    irq_ack <= 3'h1;
    @(posedge pclk);
    irq_ack <= 3'h0;
    repeat (2) @(posedge pclk);
    chk(irq_req, 3'h0);
    $display("test overflow done");

    wr(t8c_pkg::T8C_OFS_CMP_A, 8'h05);
    rchk(t8c_pkg::T8C_OFS_CMP_A, 8'h05);
    wr(t8c_pkg::T8C_OFS_COUNT, 8'h04);
    tick();
    rchk(t8c_pkg::T8C_OFS_FLAGS, 8'h00);
    tick();
    rchk(t8c_pkg::T8C_OFS_FLAGS, 8'h02);
    chk(irq_req, 3'h2);
    wr(t8c_pkg::T8C_OFS_FLAGS, 8'h02);
    rchk(t8c_pkg::T8C_OFS_FLAGS, 8'h00);
    wr(t8c_pkg::T8C_OFS_COUNT, 8'h05);
    tick();
    rchk(t8c_pkg::T8C_OFS_FLAGS, 8'h00);
    rchk(t8c_pkg::T8C_OFS_COUNT, 8'h06);
    $display("test compare done");

    wr(t8c_pkg::T8C_OFS_CTRL_A, 8'h02);
    wr(t8c_pkg::T8C_OFS_CMP_A, 8'h07);
    wr(t8c_pkg::T8C_OFS_COUNT, 8'h06);
    tick();
    tick();
    rchk(t8c_pkg::T8C_OFS_COUNT, 8'h00);
    rchk(t8c_pkg::T8C_OFS_FLAGS, 8'h02);
    wr(t8c_pkg::T8C_OFS_FLAGS, 8'h07);
    $display("test clear on match done");

    wr(t8c_pkg::T8C_OFS_CTRL_A, 8'h40);
    chk(compare_pin_o, 2'h0);
    chk(compare_pin_oe, 2'h0);
    wr(t8c_pkg::T8C_OFS_COUNT, 8'h33);
    wr(t8c_pkg::T8C_OFS_CTRL_C, 8'h80);
    chk(compare_pin_o, 2'h1);
    port_dir <= 2'h1;
    rchk(t8c_pkg::T8C_OFS_FLAGS, 8'h00);
    rchk(t8c_pkg::T8C_OFS_COUNT, 8'h33);
    chk(compare_pin_oe, 2'h1);
    wr(t8c_pkg::T8C_OFS_CTRL_A, 8'h00);
    port_value <= 2'h2;
    wr(t8c_pkg::T8C_OFS_CTRL_C, 8'h80);
    chk(compare_pin_o, 2'h2);
    wr(t8c_pkg::T8C_OFS_CTRL_A, 8'h40);
    chk(compare_pin_o, 2'h3);
    wr(t8c_pkg::T8C_OFS_CTRL_A, 8'hc0);
    wr(t8c_pkg::T8C_OFS_CTRL_C, 8'h80);
    chk(compare_pin_o, 2'h3);
    wr(t8c_pkg::T8C_OFS_CTRL_A, 8'h80);
    wr(t8c_pkg::T8C_OFS_CTRL_C, 8'h80);
    chk(compare_pin_o, 2'h2);
    wr(t8c_pkg::T8C_OFS_CTRL_A, 8'h40);
    wr(t8c_pkg::T8C_OFS_CTRL_C, 8'h80);
    wr(t8c_pkg::T8C_OFS_CTRL_A, 8'h43);
    chk(compare_pin_o, 2'h3);
    $display("test outputs done");

    // Fast PWM: the write lands in the buffer and the old value keeps matching.
    wr(t8c_pkg::T8C_OFS_CTRL_A, 8'h00);
    wr(t8c_pkg::T8C_OFS_CMP_B, 8'h30);
    wr(t8c_pkg::T8C_OFS_CTRL_A, 8'h03);
    wr(t8c_pkg::T8C_OFS_CMP_B, 8'h40);
    rchk(t8c_pkg::T8C_OFS_CMP_B, 8'h40);
    wr(t8c_pkg::T8C_OFS_COUNT, 8'h2f);
    tick();
    tick();
    rchk(t8c_pkg::T8C_OFS_FLAGS, 8'h04);
    wr(t8c_pkg::T8C_OFS_CTRL_B, 8'h08);
    rchk(t8c_pkg::T8C_OFS_CTRL_B, 8'h08);
    $display("test buffer done");
    wrap_up();
  end
endmodule : timer8_compare_core_tb
